//--- hw/sarc_cfg.svh
`ifndef SARC_CFG_SVH
`define SARC_CFG_SVH
// register byte offsets
`define SARC_OFF_CTRL      8'h00
`define SARC_OFF_SAMPLE    8'h04
`define SARC_OFF_HOLD      8'h08
`define SARC_OFF_THEN      8'h0C
`define SARC_OFF_RELSEL    8'h10
`define SARC_OFF_TRIGDLY   8'h14
`define SARC_OFF_STATUS    8'h18
`define SARC_OFF_IRQSTAT   8'h1C
`define SARC_OFF_IRQMASK   8'h20
`define SARC_OFF_TOD       8'h24
`define SARC_OFF_DAY       8'h28
`define SARC_OFF_PROBE     8'h2C
`define SARC_OFF_THRESH    8'h30
`define SARC_OFF_RECORD    8'h40
`define SARC_OFF_LABEL     8'h50
`define SARC_OFF_END       8'h64
// ctrl field positions
`define SARC_CTRL_RUN      0
`define SARC_CTRL_PROBE    1
// irq status bit positions
`define SARC_IRQ_DONE      0
`define SARC_IRQ_ALARM     1
`define SARC_IRQ_RELAY     2
// reset values
`define SARC_RST_SAMPLE    16'h0001
`define SARC_RST_HOLD      16'h0001
`define SARC_RST_TRIGDLY   8'h00
// timing and memory counts
`define SARC_SEC_PER_DAY   17'd86400
`define SARC_LABEL_WORDS   5
`endif

//--- hw/sarc_label_mem.sv
`include "sarc_cfg.svh"
`default_nettype none
module sarc_label_mem (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // access port
  sarc_lbl_if.mem   bus
);
  import sarc_pkg::*;

  sarc_lbl_state_type s;       // current state
  sarc_lbl_state_type next_s;  // next state

  // write masks each byte to seven-bit ASCII, read is registered
  always_comb begin
    next_s = s;
    if (bus.we && bus.addr < 3'(`SARC_LABEL_WORDS)) begin
      next_s.word[bus.addr] = bus.wdata & 32'h7F7F_7F7F;
    end
    if (bus.addr < 3'(`SARC_LABEL_WORDS)) begin
      next_s.rdata = s.word[bus.addr];
    end else begin
      next_s.rdata = 32'h0000_0000;  // out of range reads zero
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign bus.rdata = s.rdata;
endmodule
`default_nettype wire

//--- hw/sarc_lbl_if.sv
`default_nettype none
interface sarc_lbl_if;
  logic        we;     // write strobe
  logic [2:0]  addr;   // word index
  logic [31:0] wdata;  // write data
  logic [31:0] rdata;  // registered read data
  modport ctl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

//--- hw/sarc_pkg.sv
`default_nettype none
package sarc_pkg;
  // operating phase, one-hot
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_HOLD   = 3'b100
  } sarc_phase_type;

  // whole state of the control block
  typedef struct packed {
    logic [2:0][6:0]  sync;       // pin synchroniser stages
    logic [6:0]       lvl;        // accepted pin levels
    sarc_phase_type   phase;      // sample / hold phase
    logic [15:0]      sample_time;
    logic [15:0]      hold_time;
    logic [15:0]      sec_left;   // seconds left in phase
    logic             run;
    logic             probe_en;
    logic [3:0]       th_en;      // per-channel alarm enable
    logic [6:0]       relay_sel;  // alarm events tied to relay
    logic [7:0]       trig_delay;
    logic [7:0]       persist;    // consecutive periods with a relay-selected alarm
    logic [3:0][31:0] thresh;
    logic [3:0][31:0] count;      // live counts
    logic [3:0][31:0] record;     // committed counts
    logic [2:0]       pin_alarm;  // flow/laser/scatter seen
    logic [6:0]       alarm_rec;  // committed alarm vector
    logic             relay;
    logic [16:0]      tod;        // seconds of day
    logic [15:0]      day;        // day number
    logic [2:0]       irq_stat;
    logic [2:0]       irq_mask;
    logic             irq;
    logic [15:0]      probe_val;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } sarc_state_type;

  // label memory state
  typedef struct packed {
    logic [4:0][31:0] word;
    logic [31:0]      rdata;
  } sarc_lbl_state_type;
endpackage
`default_nettype wire

//--- hw/sarc_top.sv
`include "sarc_cfg.svh"
`default_nettype none
module sarc_top #(
  parameter int CH_USED = 4  // channels built, 2 or 4
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // sensor pins
  input  wire logic [3:0]  i_particle,
  input  wire logic        i_flow_alarm,
  input  wire logic        i_laser_alarm,
  input  wire logic        i_scatter_alarm,
  // same-clock inputs
  input  wire logic        i_sec_tick,
  input  wire logic [15:0] i_probe_data,
  // outputs
  output logic             o_relay,
  output logic             o_counting,
  output logic             o_probe_en,
  output logic             o_irq
);
  import sarc_pkg::*;

  sarc_state_type s;       // current state
  sarc_state_type next_s;  // next state
  sarc_lbl_if     lbl ();  // label memory port

  logic [6:0]  rise;       // accepted rising edges
  logic [6:0]  alarm;      // alarm vector at commit
  logic        sample_end; // sample period ends this cycle
  logic        hit;        // selected alarm present
  logic [2:0]  irq_set;    // events this cycle
  logic [2:0]  irq_clr;    // software clears
  logic        first_acc;  // first access cycle
  logic        done;       // transfer completes
  logic [7:0]  waddr;      // word-aligned address
  logic [7:0]  rel;        // offset inside an array
  logic [31:0] rdata;      // read mux
  logic        mapped;     // address decodes
  logic [7:0]  pnext;      // persistence plus one

  // label memory
  sarc_label_mem u_label (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .bus     (lbl)
  );

  // label port driven straight from the bus
  always_comb begin
    waddr     = {i_paddr[7:2], 2'b00};
    rel       = waddr - `SARC_OFF_LABEL;
    lbl.addr  = rel[4:2];
    lbl.wdata = i_pwdata;
    lbl.we    = i_psel && i_penable && s.pready && i_pwrite
                && waddr >= `SARC_OFF_LABEL && waddr < `SARC_OFF_END;
  end

  // read decode, every register one aligned word
  always_comb begin
    mapped = 1'b1;
    rdata  = 32'h0000_0000;
    if (waddr >= `SARC_OFF_LABEL && waddr < `SARC_OFF_END) begin
      rdata = lbl.rdata;
    end else if (waddr >= `SARC_OFF_RECORD && waddr < `SARC_OFF_LABEL) begin
      rdata = s.record[i_paddr[3:2]];
    end else if (waddr >= `SARC_OFF_THRESH && waddr < `SARC_OFF_RECORD) begin
      rdata = s.thresh[i_paddr[3:2]];
    end else begin
      case (waddr)
        `SARC_OFF_CTRL:    rdata = {30'h0000_0000, s.probe_en, s.run};
        `SARC_OFF_SAMPLE:  rdata = {16'h0000, s.sample_time};
        `SARC_OFF_HOLD:    rdata = {16'h0000, s.hold_time};
        `SARC_OFF_THEN:    rdata = {28'h000_0000, s.th_en};
        `SARC_OFF_RELSEL:  rdata = {25'h000_0000, s.relay_sel};
        `SARC_OFF_TRIGDLY: rdata = {24'h00_0000, s.trig_delay};
        `SARC_OFF_STATUS:  rdata = {5'h00, s.persist, s.sec_left[7:0],
                                    s.alarm_rec, s.relay, s.phase};
        `SARC_OFF_IRQSTAT: rdata = {29'h0000_0000, s.irq_stat};
        `SARC_OFF_IRQMASK: rdata = {29'h0000_0000, s.irq_mask};
        `SARC_OFF_TOD:     rdata = {15'h0000, s.tod};
        `SARC_OFF_DAY:     rdata = {16'h0000, s.day};
        `SARC_OFF_PROBE:   rdata = {16'h0000, s.probe_val};
        default:           mapped = 1'b0;  // unmapped answers error
      endcase
    end
  end

  // next-state logic
  always_comb begin
    next_s     = s;
    sample_end = 1'b0;
    alarm      = 7'h00;
    hit        = 1'b0;
    pnext      = 8'h00;
    irq_set    = 3'h0;
    irq_clr    = 3'h0;
    first_acc  = i_psel && i_penable && !s.pready;
    done       = i_psel && i_penable && s.pready;

    // three-stage pin sync, change taken when stages two and three agree
    next_s.sync[0] = {i_scatter_alarm, i_laser_alarm, i_flow_alarm, i_particle};
    next_s.sync[1] = s.sync[0];
    next_s.sync[2] = s.sync[1];
    for (int i = 0; i < 7; i++) begin
      if (s.sync[1][i] == s.sync[2][i]) begin
        next_s.lvl[i] = s.sync[2][i];
      end
    end
    rise = next_s.lvl & ~s.lvl;

    // time of day, rolls into the day count
    if (i_sec_tick) begin
      if (s.tod == `SARC_SEC_PER_DAY - 17'd1) begin
        next_s.tod = 17'h0_0000;
        next_s.day = s.day + 16'h0001;
      end else begin
        next_s.tod = s.tod + 17'h0_0001;
      end
    end

    // sample / hold sequencer
    unique case (s.phase)
      ST_IDLE: begin
        // start a fresh sample period
        if (s.run) begin
          next_s.phase     = ST_SAMPLE;
          next_s.sec_left  = s.sample_time;
          next_s.count     = '0;
          next_s.pin_alarm = 3'h0;
        end
      end
      ST_SAMPLE: begin
        // counting happens only here
        for (int i = 0; i < 4; i++) begin
          next_s.count[i] = s.count[i] + {31'h0000_0000, rise[i]};
        end
        next_s.pin_alarm = s.pin_alarm | s.lvl[6:4];
        if (i_sec_tick) begin
          if (s.sec_left <= 16'h0001) begin
            sample_end      = 1'b1;
            next_s.phase    = ST_HOLD;
            next_s.sec_left = s.hold_time;
          end else begin
            next_s.sec_left = s.sec_left - 16'h0001;
          end
        end
      end
      ST_HOLD: begin
        // no counting while holding
        if (i_sec_tick) begin
          if (s.sec_left <= 16'h0001) begin
            next_s.phase     = ST_SAMPLE;
            next_s.sec_left  = s.sample_time;
            next_s.count     = '0;
            next_s.pin_alarm = 3'h0;
          end else begin
            next_s.sec_left = s.sec_left - 16'h0001;
          end
        end
      end
      default: begin
        next_s.phase = ST_IDLE;  // illegal code recovers
      end
    endcase
    if (!s.run) begin
      next_s.phase = ST_IDLE;  // stop aborts the period
    end

    // commit record, evaluate alarms and relay
    if (sample_end) begin
      next_s.record = next_s.count;
      for (int i = 0; i < 4; i++) begin
        alarm[i] = s.th_en[i] && (i < CH_USED)
                   && next_s.count[i] >= s.thresh[i];
      end
      alarm[6:4]       = next_s.pin_alarm;
      next_s.alarm_rec = alarm;
      hit              = |(alarm & s.relay_sel);
      pnext            = (s.persist == 8'hFF) ? 8'hFF : s.persist + 8'h01;
      if (hit) begin
        next_s.persist = pnext;
        // zero delay closes at once, else after N periods in a row
        next_s.relay = (pnext >= s.trig_delay) || s.relay;
      end else begin
        next_s.persist = 8'h00;
        next_s.relay   = 1'b0;
      end
      irq_set[`SARC_IRQ_DONE]  = 1'b1;
      irq_set[`SARC_IRQ_ALARM] = |alarm;
      irq_set[`SARC_IRQ_RELAY] = next_s.relay && !s.relay;
    end

    // probe value visible only when enabled
    next_s.probe_val = s.probe_en ? i_probe_data : 16'h0000;

    // apb: one wait state, prdata and pready from flops
    next_s.pready  = first_acc;
    next_s.pslverr = first_acc && !mapped;
    // read data stands only in the answer cycle of a mapped read, else zero
    next_s.prdata = (first_acc && mapped && !i_pwrite) ? rdata : 32'h0000_0000;

    // register writes on the completing edge
    if (done && i_pwrite) begin
      if (waddr >= `SARC_OFF_THRESH && waddr < `SARC_OFF_RECORD) begin
        next_s.thresh[i_paddr[3:2]] = i_pwdata;
      end
      case (waddr)
        `SARC_OFF_CTRL: begin
          next_s.run      = i_pwdata[`SARC_CTRL_RUN];
          next_s.probe_en = i_pwdata[`SARC_CTRL_PROBE];
        end
        `SARC_OFF_SAMPLE: begin
          // zero is clamped to the one-second floor
          next_s.sample_time = (i_pwdata[15:0] == 16'h0000) ? 16'h0001
                               : i_pwdata[15:0];
        end
        `SARC_OFF_HOLD: begin
          next_s.hold_time = (i_pwdata[15:0] == 16'h0000) ? 16'h0001
                             : i_pwdata[15:0];
        end
        `SARC_OFF_THEN:    next_s.th_en      = i_pwdata[3:0];
        `SARC_OFF_RELSEL:  next_s.relay_sel  = i_pwdata[6:0];
        `SARC_OFF_TRIGDLY: next_s.trig_delay = i_pwdata[7:0];
        `SARC_OFF_IRQSTAT: irq_clr           = i_pwdata[2:0];
        `SARC_OFF_IRQMASK: next_s.irq_mask   = i_pwdata[2:0];
        `SARC_OFF_TOD: begin
          // out-of-range time of day is forced to midnight
          next_s.tod = (i_pwdata[16:0] < `SARC_SEC_PER_DAY) ? i_pwdata[16:0]
                       : 17'h0_0000;
        end
        `SARC_OFF_DAY:     next_s.day = i_pwdata[15:0];
        default: begin
          // read-only or label words
        end
      endcase
    end

    // sticky status, set beats clear in the same cycle
    next_s.irq_stat = (s.irq_stat & ~irq_clr) | irq_set;
    next_s.irq      = |(next_s.irq_stat & next_s.irq_mask);
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s             <= '0;
      s.phase       <= ST_IDLE;
      s.sample_time <= `SARC_RST_SAMPLE;
      s.hold_time   <= `SARC_RST_HOLD;
      s.trig_delay  <= `SARC_RST_TRIGDLY;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flops
  assign o_prdata   = s.prdata;
  assign o_pready   = s.pready;
  assign o_pslverr  = s.pslverr;
  assign o_relay    = s.relay;
  assign o_counting = s.phase[1];
  assign o_probe_en = s.probe_en;
  assign o_irq      = s.irq;
endmodule
`default_nettype wire

//--- verification/sample_alarm_relay_control_tb_top.sv
`include "sarc_cfg.svh"
`default_nettype none
module sample_alarm_relay_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;     // system clock
  logic        rst_n = 1'b0;   // reset, active low
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  particle = 4'h0; // particle pins
  logic [2:0]  pin_al = 3'h0;   // flow, laser, scatter alarm pins
  logic        sec_tick = 1'b0; // seconds pulse
  logic [15:0] probe = 16'h0;   // probe reading
  logic        relay, counting, probe_en, irq;
  int          err_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  initial forever #5 clk = ~clk;
  sarc_top #(.CH_USED(2)) sarc_top_i (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_particle(particle),
    .i_flow_alarm(pin_al[0]), .i_laser_alarm(pin_al[1]), .i_scatter_alarm(pin_al[2]),
    .i_sec_tick(sec_tick), .i_probe_data(probe), .o_relay(relay), .o_counting(counting),
    .o_probe_en(probe_en), .o_irq(irq));
  sarc_host_model sarc_host_model_i (.i_clk(clk), .o_psel(psel), .o_penable(penable),
    .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata),
    .i_pready(pready), .i_pslverr(pslverr));
  // verdict and end of run
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    sarc_host_model_i.xfer(1'b1, a, d, r, e);
  endtask
  // read and compare data and error flag
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    sarc_host_model_i.xfer(1'b0, a, 32'h0, r, e);
    chk("rdata", x, r);
    chk("slverr", {31'h0, xe}, {31'h0, e});
  endtask
  task automatic tick;
    @(posedge clk) sec_tick <= 1'b1;
    @(posedge clk) sec_tick <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk) particle <= 4'hf;
      repeat (4) @(posedge clk);
      particle <= 4'h0;
      repeat (4) @(posedge clk);
    end
  endtask
  // hold to sample, n particles, then commit
  task automatic period(input int n);
    tick();
    chk("counting", 32'h1, {31'h0, counting});
    pulse(n);
    tick();
  endtask
  task automatic t_reset_regs;
    rd(`SARC_OFF_SAMPLE, 32'h1, 1'b0);
    rd(`SARC_OFF_HOLD, 32'h1, 1'b0);
    rd(`SARC_OFF_TRIGDLY, 32'h0, 1'b0);
    rd(`SARC_OFF_END, 32'h0, 1'b1);
  endtask
  task automatic t_label_time;
    wr(`SARC_OFF_LABEL, 32'hc1c2_4344);
    rd(`SARC_OFF_LABEL, 32'h4142_4344, 1'b0);
    wr(`SARC_OFF_TOD, 32'd100);
    wr(`SARC_OFF_TOD, 32'd200);
    rd(`SARC_OFF_TOD, 32'd200, 1'b0);
    wr(`SARC_OFF_TOD, 32'd86399);
    tick();
    rd(`SARC_OFF_TOD, 32'd0, 1'b0);
    rd(`SARC_OFF_DAY, 32'd1, 1'b0);
  endtask
  task automatic t_probe;
    probe <= 16'h1234;
    rd(`SARC_OFF_PROBE, 32'h0, 1'b0);
    wr(`SARC_OFF_CTRL, 32'h2);
    @(posedge clk);
    chk("probe_en", 32'h1, {31'h0, probe_en});
    rd(`SARC_OFF_PROBE, 32'h1234, 1'b0);
  endtask
  // ch0 below threshold, ch2 enabled but beyond the build: neither may alarm
  task automatic t_gate;
    wr(`SARC_OFF_THRESH, 32'h2);
    wr(`SARC_OFF_THEN, 32'h5);
    wr(`SARC_OFF_RELSEL, 32'h5);
    wr(`SARC_OFF_IRQMASK, 32'h7);
    wr(`SARC_OFF_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    chk("counting", 32'h1, {31'h0, counting});
    tick();
    chk("relay", 32'h0, {31'h0, relay});
    chk("hold", 32'h0, {31'h0, counting});
    chk("irq", 32'h1, {31'h0, irq});
    wr(`SARC_OFF_IRQSTAT, 32'h7);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
  endtask
  task automatic t_immediate;
    period(2);
    chk("relay", 32'h1, {31'h0, relay});
    rd(`SARC_OFF_RECORD, 32'h2, 1'b0);
    pulse(3);
    period(0);
    rd(`SARC_OFF_RECORD, 32'h0, 1'b0);
    chk("relay", 32'h0, {31'h0, relay});
  endtask
  task automatic t_delay;
    wr(`SARC_OFF_TRIGDLY, 32'h2);
    period(2);
    chk("relay", 32'h0, {31'h0, relay});
    period(0);
    period(2);
    chk("relay", 32'h0, {31'h0, relay});
    period(2);
    chk("relay", 32'h1, {31'h0, relay});
    rd(`SARC_OFF_STATUS, 32'h0010_081C, 1'b0);
    wr(`SARC_OFF_RELSEL, 32'h0);
    period(2);
    chk("relay", 32'h0, {31'h0, relay});
    wr(`SARC_OFF_IRQMASK, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    // flow alarm pin selected alone closes the relay
    wr(`SARC_OFF_TRIGDLY, 32'h0);
    wr(`SARC_OFF_RELSEL, 32'h10);
    pin_al <= 3'h1;
    period(0);
    chk("relay", 32'h1, {31'h0, relay});
    pin_al <= 3'h0;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_regs();
    t_label_time();
    t_probe();
    t_gate();
    t_immediate();
    t_delay();
    finish_test();
  end
endmodule
`default_nettype wire

//--- verification/sarc_host_model.sv
`default_nettype none
module sarc_host_model (
  // clock
  input wire logic        i_clk,
  // apb master side
  output var logic        o_psel,
  output var logic        o_penable,
  output var logic        o_pwrite,
  output var logic [7:0]  o_paddr,
  output var logic [31:0] o_pwdata,
  input wire logic [31:0] i_prdata,
  input wire logic        i_pready,
  input wire logic        i_pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idle at time zero
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h0;
    o_pwdata = 32'h0;
  end
  // one transfer: setup, access held until answered
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    do @(posedge i_clk); while (i_pready !== 1'b1);
    r = i_prdata;
    e = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- verification/sarc_top_assertions.sv
`include "sarc_cfg.svh"
`default_nettype none
module sarc_top_assertions #(
  parameter int CH_USED = 4  // channels built, handed on from the top
) (
  // watched ports
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        i_sec_tick,
  input wire logic        o_relay,
  input wire logic        o_counting,
  input wire logic        o_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // one wait state, then a single answer pulse
  property p_ready_wait; i_psel && i_penable && !o_pready |=> o_pready; endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("answer late");
  property p_ready_pulse; o_pready |=> !o_pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("answer too long");
  property p_err_ready; o_pslverr |-> o_pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without answer");
  property p_rdata_idle; !o_pready |-> o_prdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not quiet");
  // addresses past the map are refused
  property p_unmapped;
    i_psel && i_penable && !o_pready && i_paddr >= `SARC_OFF_END |=> o_pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  // relay moves only at the end of a sample
  property p_relay_commit; $changed(o_relay) |-> $past(i_sec_tick) || $past(i_sec_tick, 2);
  endproperty
  a_relay_commit: assert property (p_relay_commit) else $error("relay moved off commit");
  property p_relay_hold; $rose(o_relay) |-> !o_counting; endproperty
  a_relay_hold: assert property (p_relay_hold) else $error("relay closed mid sample");
  // clearing the mask silences the interrupt
  property p_irq_mask;
    i_psel && i_penable && o_pready && i_pwrite && i_paddr == `SARC_OFF_IRQMASK
      && i_pwdata == 32'h0 |-> ##2 !o_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt stays");
  c_relay: cover property ($rose(o_relay));
  c_err: cover property (o_pslverr);
  c_irq: cover property ($fell(o_irq));
endmodule
bind sarc_top sarc_top_assertions #(.CH_USED(CH_USED)) sarc_top_assertions_i (
  .i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
  .o_pready, .o_pslverr, .i_sec_tick, .o_relay, .o_counting, .o_irq);
`default_nettype wire
